// File: inc/dds_pkg.sv
// Constants, enumerations and carrier types of the burst-of-four DDR SRAM core.
// Assumes one 25 MHz system clock; every SRAM pin is sampled, none of them clocks logic.
package dds_pkg;
   // Array geometry: burst address pins, data width, byte lanes.
   localparam int ADDR_W = 19;
   localparam int DATA_W = 36;
   localparam int BYTE_W = 9;
   localparam int BYTES = 4;
   localparam int BURST_LEN = 4;
   localparam int BEAT_W = 2;
   localparam int WORD_AW = ADDR_W + BEAT_W;
   localparam int MEM_WORDS = 1 << WORD_AW;
   // Positions are counted in K half cycles after the command edge.
   localparam int READ_LAT_HALVES = 4;
   localparam int WRITE_LAT_HALVES = 2;
   localparam int TERM_OFF_POS = READ_LAT_HALVES - 1;
   localparam int TERM_ON_POS = READ_LAT_HALVES + BURST_LEN + 1;
   localparam int PIPE_LEN = TERM_ON_POS;
   // DLL lock period in K cycles and the clock stop time.
   localparam int DLL_LOCK_CYCLES = 2048;
   localparam int LOCK_W = 12;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CLK_STOP_NS = 30;
   localparam int STOP_CYCLES_RAW = CLK_STOP_NS / CLK_PERIOD_NS;
   localparam int CLK_STOP_CYCLES = (STOP_CYCLES_RAW < 1) ? 1 : STOP_CYCLES_RAW;
   localparam int STOP_W = 16;
   // APB register map and field positions.
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
   localparam int CTRL_OPT_LSB = 0;
   localparam int CTRL_OPT_MSB = 1;
   localparam int ST_READY = 0;
   localparam int ST_DLL_LOCKED = 1;
   localparam int ST_CLK_STOPPED = 2;
   localparam int ST_DQ_TERM_ON = 3;
   localparam int ST_RD_ACTIVE = 4;
   localparam int ST_WR_ACTIVE = 5;
   typedef logic [ADDR_W-1:0] dds_addr_type;
   typedef logic [WORD_AW-1:0] dds_word_type;
   typedef logic [DATA_W-1:0] dds_data_type;
   typedef logic [BYTES-1:0] dds_ben_type;
   typedef logic [BEAT_W-1:0] dds_beat_type;
   typedef logic [PIPE_LEN-1:0] dds_pipe_type;
   typedef logic [STOP_W-1:0] dds_idle_type;
   typedef logic [LOCK_W-1:0] dds_lock_type;
   // Termination strength, the board option (reset value first) and the DLL state.
   // Strong is the lower of the two termination resistances, weak the higher.
   typedef enum logic [1:0] {TERM_OFF, TERM_STRONG, TERM_WEAK} dds_term_type;
   typedef enum logic [1:0] {OPT_ONE, OPT_TWO, OPT_NONE} dds_opt_type;
   typedef enum logic [1:0] {DLL_LOCK, DLL_WAIT, DLL_READY} dds_dll_type;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [APB_AW-1:0] paddr;
      logic [31:0] pwdata;
   } dds_apb_req_type;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dds_apb_rsp_type;
   typedef struct packed {
      logic k;
      logic k_n;
      logic load_address_n;
      logic read_write_n;
      dds_addr_type addr;
      dds_ben_type byte_write_n;
      dds_data_type dq;
      logic dll_disable_n;
      logic termination_level;
      logic termination_driven;
   } dds_pins_in_type;
   typedef struct packed {
      dds_data_type dq;
      logic dq_oe;
      dds_term_type term_clk;
      dds_term_type term_dq;
      dds_term_type term_bw;
   } dds_pins_out_type;
endpackage

// File: src/dds_sync.sv
// Three-stage pin synchroniser with an agreement filter.
// Assumes asynchronous pins; each bit moves on once stages two and three agree.
`timescale 1ns/1ps
module dds_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic resetn,
   // Raw pins and filtered levels.
   input wire logic [W-1:0] raw,
   output logic [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s0;
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] level;
   } dds_sync_state_type;
   dds_sync_state_type st;
   dds_sync_state_type next_st;

   // The first stage feeds only the second, so no logic sees a metastable value.
   always_comb begin
      next_st = st;
      next_st.s0 = raw;
      next_st.s1 = st.s0;
      next_st.s2 = st.s1;
      next_st.level = (~(st.s1 ^ st.s2) & st.s1) | ((st.s1 ^ st.s2) & st.level);
   end

   // State register.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;
endmodule

// File: src/dds_mem.sv
// Storage array with byte-lane writes and a registered read port.
// Assumes one write and one read request per cycle at most.
`timescale 1ns/1ps
module dds_mem (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic resetn,
   // Write port.
   input wire logic wr_en,
   input wire dds_pkg::dds_word_type wr_addr,
   input wire dds_pkg::dds_data_type wr_data,
   input wire dds_pkg::dds_ben_type wr_byte_en,
   // Read port.
   input wire logic rd_en,
   input wire dds_pkg::dds_word_type rd_addr,
   output dds_pkg::dds_data_type rd_data
);
   dds_pkg::dds_data_type mem [dds_pkg::MEM_WORDS];

   // Byte lanes are written alone so that masked lanes keep their old contents.
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         for (int b = 0; b < dds_pkg::BYTES; b++) begin
            if (wr_byte_en[b]) begin
               mem[wr_addr][b*dds_pkg::BYTE_W +: dds_pkg::BYTE_W] <= wr_data[b*dds_pkg::BYTE_W +: dds_pkg::BYTE_W];
            end
         end
      end
   end

   // Read data come out of a register.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// File: src/dds_core.sv
// Burst-of-four DDR SRAM core: command decode, burst engine, termination and DLL readiness.
// Assumes the K pins toggle much slower than sys_clk so every edge is seen after sampling.
`timescale 1ns/1ps
module dds_core #(
   // Cycles a clock pin must stay static before the DLL is taken as stopped.
   parameter int STOP_CYCLES = dds_pkg::CLK_STOP_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic resetn,
   // APB register port.
   input wire dds_pkg::dds_apb_req_type apb_req,
   output dds_pkg::dds_apb_rsp_type apb_rsp,
   // SRAM pins toward the memory controller.
   input wire dds_pkg::dds_pins_in_type pins_in,
   output dds_pkg::dds_pins_out_type pins_out
);
   localparam dds_pkg::dds_idle_type STOP_LIMIT = dds_pkg::dds_idle_type'(STOP_CYCLES);
   localparam dds_pkg::dds_lock_type LOCK_LAST = dds_pkg::dds_lock_type'(dds_pkg::DLL_LOCK_CYCLES - 1);

   typedef struct packed {
      logic k_prev;
      logic kn_prev;
      logic doff_prev;
      dds_pkg::dds_idle_type k_idle;
      dds_pkg::dds_idle_type kn_idle;
      logic stopped;
      dds_pkg::dds_dll_type dll;
      dds_pkg::dds_lock_type lock_cnt;
      dds_pkg::dds_pipe_type rd_pipe;
      dds_pkg::dds_pipe_type wr_pipe;
      dds_pkg::dds_addr_type rd_base;
      dds_pkg::dds_addr_type wr_base;
      logic drive_pend;
      dds_pkg::dds_opt_type opt;
      dds_pkg::dds_apb_rsp_type apb;
      dds_pkg::dds_pins_out_type pins;
   } dds_core_state_type;

   dds_core_state_type st;
   dds_core_state_type next_st;
   logic [$bits(dds_pkg::dds_pins_in_type)-1:0] pin_bits;
   dds_pkg::dds_pins_in_type pin;
   logic ev_rise;
   logic ev_half;
   logic doff_rise;
   logic stop_now;
   logic ready;
   logic busy;
   logic accept;
   logic rd_cmd;
   logic wr_cmd;
   logic rd_quiet;
   logic access;
   logic [dds_pkg::BEAT_W:0] rd_hit;
   logic [dds_pkg::BEAT_W:0] wr_hit;
   dds_pkg::dds_pipe_type rd_shift;
   dds_pkg::dds_pipe_type wr_shift;
   dds_pkg::dds_term_type dq_setting;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic mem_wr_en;
   dds_pkg::dds_word_type mem_wr_addr;
   logic mem_rd_en;
   dds_pkg::dds_word_type mem_rd_addr;
   dds_pkg::dds_data_type mem_rd_data;

   // Finds which beat of a burst sits at the given pipe position; top bit flags a hit.
   function automatic logic [dds_pkg::BEAT_W:0] beat_hit(input dds_pkg::dds_pipe_type pipe, input int first);
      logic [dds_pkg::BEAT_W:0] hit;
      hit = '0;
      for (int i = 0; i < dds_pkg::BURST_LEN; i++) begin
         if (pipe[first + i]) begin
            hit = {1'b1, dds_pkg::dds_beat_type'(i)};
         end
      end
      return hit;
   endfunction

   // Linear burst counter: the loaded address plus the beat number.
   function automatic dds_pkg::dds_word_type word_addr(input dds_pkg::dds_addr_type base,
                                                       input dds_pkg::dds_beat_type beat);
      return {base, {dds_pkg::BEAT_W{1'b0}}} + dds_pkg::dds_word_type'(beat);
   endfunction

   // Saturating count of cycles without a change on a clock pin.
   function automatic dds_pkg::dds_idle_type idle_step(input dds_pkg::dds_idle_type cnt, input logic moved);
      dds_pkg::dds_idle_type res;
      res = cnt;
      if (moved) begin
         res = '0;
      end else if (cnt < STOP_LIMIT) begin
         res = cnt + dds_pkg::dds_idle_type'(1);
      end
      return res;
   endfunction

   // Strength picked by the control pin state for the selected board option.
   function automatic dds_pkg::dds_term_type term_for(input dds_pkg::dds_opt_type opt, input logic driven,
                                                      input logic lvl);
      dds_pkg::dds_term_type t;
      t = dds_pkg::TERM_OFF;
      case (opt)
         dds_pkg::OPT_ONE: begin
            if (driven && !lvl) begin
               t = dds_pkg::TERM_STRONG;
            end else begin
               t = dds_pkg::TERM_WEAK;
            end
         end
         dds_pkg::OPT_TWO: begin
            if (driven && lvl) begin
               t = dds_pkg::TERM_WEAK;
            end
         end
         default: begin
            t = dds_pkg::TERM_OFF;
         end
      endcase
      return t;
   endfunction

   // Every pin passes the three-stage filter, so data and clocks stay aligned.
   dds_sync #(
      .W($bits(dds_pkg::dds_pins_in_type))
   ) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .raw(pins_in),
      .level(pin_bits)
   );

   assign pin = dds_pkg::dds_pins_in_type'(pin_bits);

   dds_mem u_mem (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wr_en(mem_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_data(pin.dq),
      .wr_byte_en(~pin.byte_write_n),
      .rd_en(mem_rd_en),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data)
   );

   // Next-state logic for clocks, DLL, commands, bursts, termination and registers.
   always_comb begin
      next_st = st;
      // A K rise starts a cycle; a K fall stands for the K# rise half a cycle later.
      ev_rise = pin.k & ~st.k_prev;
      ev_half = pin.k ^ st.k_prev;
      doff_rise = pin.dll_disable_n & ~st.doff_prev;
      next_st.k_prev = pin.k;
      next_st.kn_prev = pin.k_n;
      next_st.doff_prev = pin.dll_disable_n;
      next_st.k_idle = idle_step(st.k_idle, pin.k ^ st.k_prev);
      next_st.kn_idle = idle_step(st.kn_idle, pin.k_n ^ st.kn_prev);
      stop_now = (st.k_idle >= STOP_LIMIT) || (st.kn_idle >= STOP_LIMIT);
      next_st.stopped = stop_now;
      ready = (st.dll == dds_pkg::DLL_READY);

      // Lock period counted in K cycles; with the DLL disabled the same wait still applies.
      case (st.dll)
         dds_pkg::DLL_LOCK: begin
            if (ev_rise) begin
               next_st.lock_cnt = st.lock_cnt + dds_pkg::dds_lock_type'(1);
               if (st.lock_cnt == LOCK_LAST) begin
                  next_st.dll = dds_pkg::DLL_READY;
               end
            end
         end
         dds_pkg::DLL_WAIT: begin
            if (ev_rise) begin
               next_st.dll = dds_pkg::DLL_LOCK;
               next_st.lock_cnt = '0;
            end
         end
         dds_pkg::DLL_READY: begin
            next_st.lock_cnt = '0;
         end
         default: begin
            next_st.dll = dds_pkg::DLL_WAIT;
         end
      endcase
      // A stopped clock wins over a disable toggle: no edge can restart counting anyway.
      if (doff_rise) begin
         next_st.dll = dds_pkg::DLL_LOCK;
         next_st.lock_cnt = '0;
      end
      if (stop_now) begin
         next_st.dll = dds_pkg::DLL_WAIT;
         next_st.lock_cnt = '0;
      end

      // Commands are taken at a K rise, only every other rise since a burst takes two cycles.
      busy = st.rd_pipe[0] | st.wr_pipe[0] | st.rd_pipe[1] | st.wr_pipe[1];
      accept = ev_rise & ready & ~pin.load_address_n & ~busy;
      rd_cmd = accept & pin.read_write_n;
      wr_cmd = accept & ~pin.read_write_n;
      if (rd_cmd) begin
         next_st.rd_base = pin.addr;
      end
      if (wr_cmd) begin
         next_st.wr_base = pin.addr;
      end

      // Pipes only move on K edges, so a stopped clock freezes every burst in place.
      rd_shift = {st.rd_pipe[dds_pkg::PIPE_LEN-2:0], rd_cmd};
      wr_shift = {st.wr_pipe[dds_pkg::PIPE_LEN-2:0], wr_cmd};
      rd_hit = beat_hit(rd_shift, dds_pkg::READ_LAT_HALVES);
      wr_hit = beat_hit(wr_shift, dds_pkg::WRITE_LAT_HALVES);
      if (ev_half) begin
         next_st.rd_pipe = rd_shift;
         next_st.wr_pipe = wr_shift;
         next_st.drive_pend = rd_hit[dds_pkg::BEAT_W];
      end

      // Beat data go straight into the array, so a later read always sees the newest data.
      mem_wr_en = ev_half & wr_hit[dds_pkg::BEAT_W];
      mem_wr_addr = word_addr(st.wr_base, wr_hit[dds_pkg::BEAT_W-1:0]);
      mem_rd_en = ev_half & rd_hit[dds_pkg::BEAT_W];
      mem_rd_addr = word_addr(st.rd_base, rd_hit[dds_pkg::BEAT_W-1:0]);

      // Output drivers follow the beat window; without K edges they keep their last state.
      next_st.pins.dq_oe = st.drive_pend;
      if (st.drive_pend) begin
         next_st.pins.dq = mem_rd_data;
      end

      // Data termination drops from the read latency minus half a cycle to the end of the burst plus half.
      dq_setting = term_for(st.opt, pin.termination_driven, pin.termination_level);
      rd_quiet = ~|st.rd_pipe[dds_pkg::PIPE_LEN-1:dds_pkg::TERM_OFF_POS];
      next_st.pins.term_dq = rd_quiet ? dq_setting : dds_pkg::TERM_OFF;
      next_st.pins.term_bw = dq_setting;
      next_st.pins.term_clk = (st.opt == dds_pkg::OPT_ONE) ? dq_setting : dds_pkg::TERM_OFF;

      // Register images for software.
      ctrl_word = '0;
      ctrl_word[dds_pkg::CTRL_OPT_MSB:dds_pkg::CTRL_OPT_LSB] = st.opt;
      status_word = '0;
      status_word[dds_pkg::ST_READY] = ready;
      status_word[dds_pkg::ST_DLL_LOCKED] = ready & pin.dll_disable_n;
      status_word[dds_pkg::ST_CLK_STOPPED] = st.stopped;
      status_word[dds_pkg::ST_DQ_TERM_ON] = st.pins.term_dq != dds_pkg::TERM_OFF;
      status_word[dds_pkg::ST_RD_ACTIVE] = |st.rd_pipe;
      status_word[dds_pkg::ST_WR_ACTIVE] = |st.wr_pipe;

      // APB slave with one wait state; the write lands on the edge that completes it.
      access = apb_req.psel & apb_req.penable;
      next_st.apb.pready = access & ~st.apb.pready;
      next_st.apb.pslverr = 1'b0;
      next_st.apb.prdata = '0;
      if (access && !st.apb.pready) begin
         case (apb_req.paddr)
            dds_pkg::REG_CTRL: begin
               next_st.apb.prdata = ctrl_word;
            end
            dds_pkg::REG_STATUS: begin
               next_st.apb.prdata = status_word;
            end
            default: begin
               next_st.apb.pslverr = 1'b1;
            end
         endcase
      end
      if (access && st.apb.pready && apb_req.pwrite && (apb_req.paddr == dds_pkg::REG_CTRL)) begin
         next_st.opt = dds_pkg::dds_opt_type'(apb_req.pwdata[dds_pkg::CTRL_OPT_MSB:dds_pkg::CTRL_OPT_LSB]);
      end
   end

   // State register; reset leaves the DLL counting its lock period.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state register.
   assign apb_rsp = st.apb;
   assign pins_out = st.pins;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   // A read beat leaves the array and reaches the pins two cycles after its K edge.
   sequence s_beat_issue;
      ev_half && rd_hit[dds_pkg::BEAT_W];
   endsequence
   sequence s_beat_drive;
      pins_out.dq_oe && (pins_out.dq == $past(mem_rd_data));
   endsequence

   a_read_beat_out: assert property (s_beat_issue |-> ##2 s_beat_drive)
      else $error("Read beat did not reach the data pins on time.");

   a_term_read_off: assert property (st.rd_pipe[dds_pkg::TERM_OFF_POS] |=> pins_out.term_dq == dds_pkg::TERM_OFF)
      else $error("Data termination stayed on during a read burst.");

   a_term_back_on: assert property ($fell(|st.rd_pipe) |=> pins_out.term_dq == $past(dq_setting))
      else $error("Data termination did not return after the read burst.");

   a_clk_term_opt2: assert property (st.opt == dds_pkg::OPT_TWO |=> pins_out.term_clk == dds_pkg::TERM_OFF)
      else $error("Clock termination active in the second option.");

   a_bw_term_low: assert property ((st.opt == dds_pkg::OPT_ONE) && pin.termination_driven
      && !pin.termination_level |=> pins_out.term_bw == dds_pkg::TERM_STRONG)
      else $error("Byte-write termination wrong for a low control pin.");

   a_no_cmd_unready: assert property ((ev_rise && !ready) |=> !st.rd_pipe[0] && !st.wr_pipe[0])
      else $error("Command taken before the lock period ended.");

   a_nop_no_load: assert property ((ev_rise && pin.load_address_n) |=> !st.rd_pipe[0] && !st.wr_pipe[0])
      else $error("Command taken with the load control high.");

   a_stop_dll_reset: assert property (stop_now |=> st.dll == dds_pkg::DLL_WAIT && st.lock_cnt == '0)
      else $error("Stopped clock did not reset the DLL.");

   a_doff_dll_reset: assert property ((doff_rise && !stop_now) |=> st.dll == dds_pkg::DLL_LOCK && !ready)
      else $error("Disable pin rising edge did not reset the DLL.");

   a_stop_holds_dq: assert property ((st.stopped && $past(st.stopped)) |=> $stable(pins_out.dq)
      && $stable(pins_out.dq_oe))
      else $error("Data outputs changed while the clocks were stopped.");
endmodule

// File: testbench/dds_ctl_model.sv
// Memory controller model: free K pair, commands and write data.
// Assumes the core filters every pin by the same delay; K half period is eight sys_clk.
`timescale 1ns/1ps
module dds_ctl_model (
   // Clock and K run control.
   input wire logic sys_clk,
   input wire logic k_run,
   // Pins toward the core and the read sampling strobe.
   output dds_pkg::dds_pins_in_type pins,
   output logic beat_strobe
);
   logic [2:0] cnt;
   // Idle pins: no load, no byte writes, DLL on, termination pin driven low.
   initial begin
      cnt = 3'h0;
      beat_strobe = 1'b0;
      pins = '0;
      pins.k_n = 1'b1;
      pins.load_address_n = 1'b1;
      pins.byte_write_n = 4'hF;
      pins.dll_disable_n = 1'b1;
      pins.termination_driven = 1'b1;
   end
   // A stopped K pair rests at its last levels.
   always @(posedge sys_clk) begin
      if (k_run) begin
         cnt <= cnt + 3'h1;
         if (cnt == 3'h7) begin
            pins.k <= ~pins.k;
            pins.k_n <= pins.k;
         end
      end
   end
   // One cycle before the K edge that ends a half at level lvl.
   task automatic wait_pt(input logic lvl);
      do @(posedge sys_clk); while (!(cnt == 3'h6 && pins.k == lvl));
   endtask
   // One command; unwritten data lines carry the inverse of their last value.
   task automatic burst(input logic rd, input dds_pkg::dds_addr_type a, input dds_pkg::dds_data_type wd[4],
                        input dds_pkg::dds_ben_type ben);
      wait_pt(1'b0);
      pins.load_address_n <= 1'b0;
      pins.read_write_n <= rd;
      pins.addr <= a;
      for (int h = 1; h <= 11; h++) begin
         wait_pt(h[0]);
         if (h == 1) pins.load_address_n <= 1'b1;
         pins.dq <= (!rd && h >= 2 && h <= 5) ? wd[(h + 2) % 4] : ~pins.dq;
         pins.byte_write_n <= (!rd && h >= 2 && h <= 5) ? ben : 4'hF;
         beat_strobe <= rd && h >= 4 && h != 10;
         @(posedge sys_clk);
         beat_strobe <= 1'b0;
      end
   endtask
endmodule

// File: testbench/test_ddr_burst4_sram_odt_init_control.sv
// Self-checking bench of the SRAM core: registers, termination, bursts, DLL.
// Assumes dds_ctl_model drives the pins; STOP_CYCLES exceeds the K half period.
`timescale 1ns/1ps
module test_ddr_burst4_sram_odt_init_control;
   logic sys_clk;
   logic resetn;
   logic k_run;
   logic beat_strobe;
   dds_pkg::dds_apb_req_type apb_req;
   dds_pkg::dds_apb_rsp_type apb_rsp;
   dds_pkg::dds_pins_in_type pins_in;
   dds_pkg::dds_pins_out_type pins_out;
   logic [77:0] apb_q[$];
   logic [77:0] beat_q[$];
   logic [77:0] ent;
   logic [31:0] seed;
   logic [31:0] cycles;
   int fail_count;
   int comparisons;
   dds_pkg::dds_data_type wd[4];
   dds_pkg::dds_data_type ad[4];
   dds_pkg::dds_data_type xd[4];
   dds_ctl_model ctl (.sys_clk(sys_clk), .k_run(k_run), .pins(pins_in), .beat_strobe(beat_strobe));
   dds_core #(.STOP_CYCLES(20)) dut (.sys_clk(sys_clk), .resetn(resetn), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .pins_in(pins_in), .pins_out(pins_out));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Termination {clk, dq, bw} for option o, pin driven d and level l.
   function automatic logic [5:0] term_exp(input logic [1:0] o, input logic d, input logic l);
      logic [1:0] v;
      v = (d && !l) ? 2'h1 : 2'h2;
      if (o == 2'h1) v = (d && l) ? 2'h2 : 2'h0;
      if (o == 2'h2) v = 2'h0;
      return {(o == 2'h0) ? v : 2'h0, v, v};
   endfunction
   task automatic check(input logic [38:0] seen, input logic [38:0] want);
      comparisons++;
      if (seen !== want) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer; the request holds until pready is seen.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] m,
                      input logic [32:0] e);
      apb_q.push_back({6'h0, m, 6'h0, e & m});
      @(posedge sys_clk);
      apb_req <= {1'b1, 1'b0, wr, a, d};
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1);
      apb_req <= '0;
   endtask
   // Each answer or read strobe takes the oldest note of its queue.
   always @(posedge sys_clk) begin
      if (apb_rsp.pready === 1'b1 && apb_q.size() > 0) begin
         ent = apb_q.pop_front();
         check({6'h0, apb_rsp.pslverr, apb_rsp.prdata} & ent[77:39], ent[38:0]);
      end
      if (beat_strobe === 1'b1 && beat_q.size() > 0) begin
         ent = beat_q.pop_front();
         check({pins_out.dq_oe, pins_out.term_dq, pins_out.dq} & ent[77:39], ent[38:0]);
      end
      cycles <= cycles + 32'h1;
      if (cycles == 32'h15F90) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      resetn = 1'b0;
      k_run = 1'b1;
      apb_req = '0;
      seed = 32'h5B27;
      cycles = 32'h0;
      fail_count = 0;
      comparisons = 0;
      repeat (16) @(posedge sys_clk);
      check({32'h0, pins_out.dq_oe, pins_out.term_clk, pins_out.term_dq, pins_out.term_bw}, 39'h0);
      resetn <= 1'b1;
      apb(1'b0, 12'h004, 32'h0, 33'h3, 33'h0);
      // Every option against every state of the control pin.
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, 12'h000, (i % 9) / 3, 33'h1_0000_0000, 33'h0);
         ctl.pins.termination_driven <= (i % 3) != 2;
         ctl.pins.termination_level <= (i % 3) == 1;
         repeat (8) @(posedge sys_clk);
         check(39'({pins_out.term_clk, pins_out.term_dq, pins_out.term_bw}),
            39'(term_exp(2'((i % 9) / 3), (i % 3) != 2, (i % 3) == 1)));
      end
      repeat (33600) @(posedge sys_clk);
      apb(1'b0, 12'h004, 32'h0, 33'h3F, 33'h0B);
      // Two writes to the top address, the second into lanes 1 and 3 only.
      for (int n = 0; n < 4; n++) begin
         seed = xs(seed);
         wd[n] = {seed[3:0], seed};
         seed = xs(seed);
         ad[n] = {seed[3:0], seed};
         xd[n] = ad[n];
         for (int b = 1; b < 4; b += 2) xd[n][b*9 +: 9] = wd[n][b*9 +: 9];
      end
      ctl.burst(1'b0, 19'h7FFFF, ad, 4'h0);
      ctl.burst(1'b0, 19'h7FFFF, wd, 4'h5);
      beat_q.push_back({3'h7, 36'h0, 39'h0});
      for (int n = 0; n < 4; n++) beat_q.push_back({39'h7F_FFFF_FFFF, 3'h4, xd[n]});
      beat_q.push_back({3'h7, 36'h0, 39'h0});
      beat_q.push_back({3'h7, 36'h0, 3'h1, 36'h0});
      ctl.burst(1'b1, 19'h7FFFF, wd, 4'hF);
      apb(1'b0, 12'h008, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
      k_run <= 1'b0;
      repeat (40) @(posedge sys_clk);
      apb(1'b0, 12'h004, 32'h0, 33'h7, 33'h4);
      k_run <= 1'b1;
      repeat (33600) @(posedge sys_clk);
      apb(1'b0, 12'h004, 32'h0, 33'h3, 33'h3);
      ctl.pins.dll_disable_n <= 1'b0;
      repeat (40) @(posedge sys_clk);
      ctl.pins.dll_disable_n <= 1'b1;
      repeat (40) @(posedge sys_clk);
      apb(1'b0, 12'h004, 32'h0, 33'h1, 33'h0);
      // Let the checker take the last answer first; a note that was never answered is a mismatch.
      @(posedge sys_clk);
      if (apb_q.size() != 0 || beat_q.size() != 0) begin
         fail_count++;
      end
      tally_and_finish();
   end
endmodule
